/* File: ocr_pkg.sv */
package ocr_pkg;

	// ************************************************
	// Register addresses
	// ************************************************
	localparam logic [7:0] OCR_EXT_CTRL_ADDR = 8'hB1;
	localparam logic [7:0] OCR_INT_CTRL_ADDR = 8'hB2;
	localparam logic [7:0] OCR_INT_CAL_ADDR = 8'hB3;

	// ************************************************
	// Field positions and reset values
	// ************************************************
	localparam int OCR_INT_EN_BIT = 7;
	localparam int OCR_INT_RDY_BIT = 6;
	localparam logic [5:0] OCR_INT_RSVD_VAL = 6'h0F;
	localparam int OCR_SSE_BIT = 7;
	localparam int OCR_EXT_VLD_BIT = 7;
	localparam int OCR_EXT_MODE_LSB = 4;
	localparam int OCR_EXT_BIAS_LSB = 0;
	localparam logic OCR_INT_EN_RST = 1'b0;
	localparam logic OCR_SSE_RST = 1'b0;
	localparam logic [2:0] OCR_EXT_MODE_RST = 3'h0;
	localparam logic [2:0] OCR_EXT_BIAS_RST = 3'h0;

	// ************************************************
	// External oscillator modes
	// ************************************************
	localparam logic [2:0] OCR_XMODE_OFF0 = 3'h0;
	localparam logic [2:0] OCR_XMODE_OFF1 = 3'h1;
	localparam logic [2:0] OCR_XMODE_CMOS = 3'h2;
	localparam logic [2:0] OCR_XMODE_CMOS_DIV2 = 3'h3;
	localparam logic [2:0] OCR_XMODE_RC = 3'h4;
	localparam logic [2:0] OCR_XMODE_CAP = 3'h5;
	localparam logic [2:0] OCR_XMODE_XTAL_DIV2 = 3'h6;

	// ************************************************
	// Timing and frequency
	// ************************************************
	localparam int OCR_CLK_PERIOD_PS = 5000;
	localparam int OCR_INT_SETTLE_NS = 1000;
	localparam int OCR_INT_SETTLE_CYC =
		(OCR_INT_SETTLE_NS * 1000 + OCR_CLK_PERIOD_PS - 1) / OCR_CLK_PERIOD_PS;
	localparam int OCR_DITHER_DIV_CYC = 16;
	localparam int OCR_NOM_FREQ_KHZ = 24500;
	localparam int OCR_TRIM_STEP_KHZ = OCR_NOM_FREQ_KHZ / 100;

	// ************************************************
	// Oscillator configuration carrier
	// ************************************************
	typedef struct packed {
		logic int_osc_enable;
		logic spread_spectrum_enable;
		logic [6:0] int_osc_trim;
		logic [2:0] ext_osc_mode_select;
		logic [2:0] ext_osc_bias_control;
	} ocr_osc_cfg_t;

endpackage : ocr_pkg

/* File: ocr_regs.sv */
`timescale 1ns/1ps
// Function
// - Enable bit 7 runs internal oscillator
// - Bit 6 ready flag, read only
// - Low six bits read 001111b, writes ignored
// - Calibration bit 7 enables spread spectrum
// - Seven-bit trim loaded from factory value
// - Higher trim gives lower frequency
// - One trim count moves about 1%
// - External bit 7 is read-only valid flag
// - Valid flag reads 0 in CMOS modes
// - Modes 00x off, 010 CMOS, 011 CMOS/2
// - Modes 100 RC, 101 C, 110 crystal/2
// - External bit 3 reads 0, writes ignored
// - Bits 2:0 set external bias current
module ocr_regs #(
	parameter int SETTLE_CYC = ocr_pkg::OCR_INT_SETTLE_CYC,
	parameter int DITHER_DIV = ocr_pkg::OCR_DITHER_DIV_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic [6:0] factory_trim,
	input wire logic ext_osc_stable,
	output ocr_pkg::ocr_osc_cfg_t osc_cfg,
	output logic int_osc_ready_flag,
	output logic ext_osc_valid_flag,
	output logic [3:0] dither_offset,
	output logic [15:0] int_osc_freq_khz
);

	// ************************************************
	// Helpers
	// ************************************************
	function automatic logic [15:0] trim_to_khz(input logic [6:0] trim, input logic [6:0] cal);
		int f;
		f = ocr_pkg::OCR_NOM_FREQ_KHZ + ocr_pkg::OCR_TRIM_STEP_KHZ * (int'(cal) - int'(trim));
		if (f < 0) begin
			f = 0;
		end
		return 16'(f);
	endfunction : trim_to_khz

	function automatic logic ext_mode_self_osc(input logic [2:0] m);
		return (m == ocr_pkg::OCR_XMODE_RC) || (m == ocr_pkg::OCR_XMODE_CAP) ||
			(m == ocr_pkg::OCR_XMODE_XTAL_DIV2);
	endfunction : ext_mode_self_osc

	// ************************************************
	// State
	// ************************************************
	logic int_en_q;
	logic sse_q;
	logic [6:0] trim_q;
	logic [6:0] cal_q;
	logic trim_loaded_q;
	logic [2:0] xmode_q;
	logic [2:0] xbias_q;
	logic [$clog2(SETTLE_CYC + 1) - 1:0] settle_q;
	logic [$clog2(DITHER_DIV) - 1:0] div_q;
	logic [7:0] lfsr_q;
	logic ext_stable_s;

	// ************************************************
	// Decode
	// ************************************************
	wire wr_int = sfr_wr && (sfr_addr == ocr_pkg::OCR_INT_CTRL_ADDR);
	wire wr_cal = sfr_wr && (sfr_addr == ocr_pkg::OCR_INT_CAL_ADDR);
	wire wr_ext = sfr_wr && (sfr_addr == ocr_pkg::OCR_EXT_CTRL_ADDR);
	wire settled = (settle_q == ($bits(settle_q))'(SETTLE_CYC));
	wire rdy_d = int_en_q && settled;
	wire xmode_self = ext_mode_self_osc(xmode_q);
	wire xvld_d = xmode_self && ext_stable_s;
	wire dither_tick = (div_q == ($bits(div_q))'(DITHER_DIV - 1));
	wire [7:0] int_rd = {int_en_q, rdy_d, ocr_pkg::OCR_INT_RSVD_VAL};
	wire [7:0] cal_rd = {sse_q, trim_q};
	wire [7:0] ext_rd = {xvld_d, xmode_q, 1'b0, xbias_q};
	wire [7:0] rd_mux = (sfr_addr == ocr_pkg::OCR_INT_CTRL_ADDR) ? int_rd :
		(sfr_addr == ocr_pkg::OCR_INT_CAL_ADDR) ? cal_rd :
		(sfr_addr == ocr_pkg::OCR_EXT_CTRL_ADDR) ? ext_rd : 8'h00;

	ocr_sync3 u_ext_sync (
		.clk(clk),
		.rst(rst),
		.d(ext_osc_stable),
		.q(ext_stable_s)
	);

	// ************************************************
	// Internal oscillator control
	// ************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			int_en_q <= ocr_pkg::OCR_INT_EN_RST;
			sse_q <= ocr_pkg::OCR_SSE_RST;
		end else begin
			if (wr_int) begin
				int_en_q <= sfr_wdata[ocr_pkg::OCR_INT_EN_BIT];
			end
			if (wr_cal) begin
				sse_q <= sfr_wdata[ocr_pkg::OCR_SSE_BIT];
			end
		end
	end

	// Trim capture after reset release
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			trim_q <= 7'h00;
			cal_q <= 7'h00;
			trim_loaded_q <= 1'b0;
		end else if (!trim_loaded_q) begin
			trim_q <= factory_trim;
			cal_q <= factory_trim;
			trim_loaded_q <= 1'b1;
		end else if (wr_cal) begin
			trim_q <= sfr_wdata[6:0];
		end
	end

	// Settling counter
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			settle_q <= '0;
		end else if (!int_en_q || (wr_cal && trim_loaded_q)) begin
			settle_q <= '0;
		end else if (!settled) begin
			settle_q <= settle_q + 1'b1;
		end
	end

	// ************************************************
	// Spread spectrum dither
	// ************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div_q <= '0;
			lfsr_q <= 8'h01;
		end else begin
			div_q <= dither_tick ? '0 : div_q + 1'b1;
			if (dither_tick && sse_q && int_en_q) begin
				lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
			end
		end
	end

	// ************************************************
	// External oscillator control
	// ************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			xmode_q <= ocr_pkg::OCR_EXT_MODE_RST;
			xbias_q <= ocr_pkg::OCR_EXT_BIAS_RST;
		end else if (wr_ext) begin
			xmode_q <= sfr_wdata[ocr_pkg::OCR_EXT_MODE_LSB +: 3];
			xbias_q <= sfr_wdata[ocr_pkg::OCR_EXT_BIAS_LSB +: 3];
		end
	end

	// ************************************************
	// Registered outputs
	// ************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sfr_rdata <= 8'h00;
			osc_cfg <= '0;
			int_osc_ready_flag <= 1'b0;
			ext_osc_valid_flag <= 1'b0;
			dither_offset <= 4'h0;
			int_osc_freq_khz <= 16'h0000;
		end else begin
			if (sfr_rd) begin
				sfr_rdata <= rd_mux;
			end
			osc_cfg.int_osc_enable <= int_en_q;
			osc_cfg.spread_spectrum_enable <= sse_q;
			osc_cfg.int_osc_trim <= trim_q;
			osc_cfg.ext_osc_mode_select <= xmode_q;
			osc_cfg.ext_osc_bias_control <= xbias_q;
			int_osc_ready_flag <= rdy_d;
			ext_osc_valid_flag <= xvld_d;
			dither_offset <= (sse_q && int_en_q) ? lfsr_q[3:0] : 4'h0;
			int_osc_freq_khz <= int_en_q ? trim_to_khz(trim_q, cal_q) : 16'h0000;
		end
	end

endmodule : ocr_regs

/* File: ocr_regs_sva.sv */
`timescale 1ns/1ps
module ocr_regs_sva #(
	parameter int SETTLE_CYC = ocr_pkg::OCR_INT_SETTLE_CYC
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire ocr_pkg::ocr_osc_cfg_t osc_cfg,
	input wire logic int_osc_ready_flag,
	input wire logic ext_osc_valid_flag,
	input wire logic [3:0] dither_offset
);
	// ************************************************
	// Register and flag checks
	// ************************************************
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	localparam int RDY_LO = SETTLE_CYC - 2;
	localparam int RDY_HI = SETTLE_CYC;
	wire [2:0] xm = osc_cfg.ext_osc_mode_select;
	wire en = osc_cfg.int_osc_enable;
	chk_en_write: assert property (
		sfr_wr && sfr_addr == 8'hB2 |-> ##2 en == $past(sfr_wdata[7], 2))
		else $error("enable not applied");
	chk_rdy_off: assert property (
		!en [*2] |-> !int_osc_ready_flag) else $error("ready while disabled");
	chk_rdy_settle: assert property (
		$rose(en) |-> !int_osc_ready_flag [*3] ##[RDY_LO:RDY_HI] int_osc_ready_flag)
		else $error("ready timing wrong");
	chk_int_rd: assert property (
		sfr_rd && sfr_addr == 8'hB2 |=> sfr_rdata[5:0] == 6'h0F) else $error("reserved bits wrong");
	chk_ext_rd: assert property (
		sfr_rd && !sfr_wr && sfr_addr == 8'hB1
		|=> sfr_rdata[6:0] == {xm, 1'b0, osc_cfg.ext_osc_bias_control})
		else $error("ext readback wrong");
	chk_cal_rd: assert property (
		sfr_rd && !sfr_wr && sfr_addr == 8'hB3
		|=> sfr_rdata == {osc_cfg.spread_spectrum_enable, osc_cfg.int_osc_trim})
		else $error("cal readback wrong");
	chk_valid_mode: assert property (
		ext_osc_valid_flag |-> xm inside {3'h4, 3'h5, 3'h6}) else $error("valid in bad mode");
	chk_cmos_valid: assert property (
		xm inside {3'h2, 3'h3} [*3] |-> !ext_osc_valid_flag) else $error("valid in cmos mode");
	chk_dither_off: assert property (
		!osc_cfg.spread_spectrum_enable [*2] |-> dither_offset == 4'h0) else $error("dither leak");
	cover property ($rose(int_osc_ready_flag));
	cover property ($rose(ext_osc_valid_flag));
	cover property (sfr_wr && sfr_addr == 8'hB3);
endmodule : ocr_regs_sva
bind ocr_regs ocr_regs_sva #(.SETTLE_CYC(SETTLE_CYC)) i_sva (.clk, .rst, .sfr_addr, .sfr_wdata,
	.sfr_wr, .sfr_rd,
	.sfr_rdata, .osc_cfg, .int_osc_ready_flag, .ext_osc_valid_flag, .dither_offset);

/* File: ocr_sync3.sv */
`timescale 1ns/1ps
module ocr_sync3 (
	input wire logic clk,
	input wire logic rst,
	input wire logic d,
	output logic q
);

	logic s1_q;
	logic s2_q;
	logic s3_q;

	// ************************************************
	// Three stages, accept when last two agree
	// ************************************************
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			q <= 1'b0;
		end else begin
			s1_q <= d;
			s2_q <= s1_q;
			s3_q <= s2_q;
			if (s2_q == s3_q) begin
				q <= s3_q;
			end
		end
	end

endmodule : ocr_sync3

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
	// ************************************************
	// Stimulus and checking
	// ************************************************
	localparam logic [7:0] XC = ocr_pkg::OCR_EXT_CTRL_ADDR;
	localparam logic [7:0] IC = ocr_pkg::OCR_INT_CTRL_ADDR;
	localparam logic [7:0] CA = ocr_pkg::OCR_INT_CAL_ADDR;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] sfr_addr = 8'h00;
	logic [7:0] sfr_wdata = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_rdata;
	logic [6:0] factory_trim = 7'h40;
	logic ext_osc_stable = 1'b0;
	ocr_pkg::ocr_osc_cfg_t osc_cfg;
	logic int_osc_ready_flag;
	logic ext_osc_valid_flag;
	logic [3:0] dither_offset;
	logic [15:0] int_osc_freq_khz;
	logic [2:0] m;
	logic v;
	int err_total = 0;
	int checks = 0;
	always #2.5 clk = ~clk;
	ocr_regs #(.SETTLE_CYC(4), .DITHER_DIV(2)) i_dut (.clk(clk), .rst(rst),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_rdata(sfr_rdata), .factory_trim(factory_trim), .ext_osc_stable(ext_osc_stable),
		.osc_cfg(osc_cfg), .int_osc_ready_flag(int_osc_ready_flag),
		.ext_osc_valid_flag(ext_osc_valid_flag), .dither_offset(dither_offset),
		.int_osc_freq_khz(int_osc_freq_khz));
	task automatic end_sim;
		$display("err_total=%0d checks=%0d", err_total, checks);
		if (err_total == 0 && checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : end_sim
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk);
		#1;
		sfr_wr = 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		#1;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge clk);
		#1;
		sfr_rd = 1'b0;
		cmp({8'h00, sfr_rdata}, {8'h00, e});
	endtask : rd
	task automatic wait_rdy;
		for (int i = 0; i < 40 && int_osc_ready_flag !== 1'b1; i++) begin
			#5;
		end
		if (int_osc_ready_flag !== 1'b1) begin
			err_total++;
			end_sim();
		end
	endtask : wait_rdy
	initial begin
		repeat (6) @(posedge clk);
		#1;
		rst = 1'b0;
		repeat (2) @(posedge clk);
		rd(XC, 8'h00);
		rd(IC, 8'h0F);
		rd(CA, 8'h40);
		wr(CA, 8'hC5);
		rd(CA, 8'hC5);
		wr(IC, 8'h8F);
		rd(IC, 8'h8F);
		wait_rdy();
		rd(IC, 8'hCF);
		cmp(int_osc_freq_khz, 16'h5AEB);
		cmp({1'b0, osc_cfg}, {1'b0, 1'b1, 1'b1, 7'h45, 3'h0, 3'h0});
		wr(IC, 8'h0F);
		rd(IC, 8'h0F);
		cmp({12'h000, dither_offset}, 16'h0000);
		ext_osc_stable = 1'b1;
		for (int i = 0; i < 8; i++) begin
			m = 3'(i);
			v = m inside {3'h4, 3'h5, 3'h6};
			wr(XC, {1'b1, m, 1'b0, ~m});
			#40;
			cmp({15'h0000, ext_osc_valid_flag}, {15'h0000, v});
			rd(XC, {v, m, 1'b0, ~m});
		end
		ext_osc_stable = 1'b0;
		wr(XC, 8'h40);
		#40;
		cmp({15'h0000, ext_osc_valid_flag}, 16'h0000);
		end_sim();
	end
endmodule : testbench
